/* File: core/cpp_sfr_bank.sv */
`timescale 1ns/1ps
module cpp_sfr_bank
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic stack_push,
    input wire logic stack_pop,
    output logic [7:0] stack_addr,
    output logic [15:0] active_data_pointer,
    input wire logic hw_config_bus_mode,
    input wire logic ext_cycle,
    input wire logic ext_ale,
    input wire logic [7:0] ext_addr_low,
    input wire logic [7:0] ext_wdata,
    input wire logic ext_write,
    input wire logic [7:0] port_zero_in,
    output logic [7:0] port_zero_out,
    output logic [7:0] port_zero_oe,
    output logic [7:0] port_zero_dir_low,
    output logic [7:0] port_zero_dir_high,
    output logic [7:0] ext_rdata,
    output logic uart0_baud_doubler,
    input wire logic aux_irq_wake,
    input wire logic wake_up_irq,
    output logic core_freeze,
    output logic osc_halt,
    output logic ref_shutdown
);
    logic [7:0] port0_q;
    logic [7:0] dp0_lo_q;
    logic [7:0] dp0_hi_q;
    logic [7:0] dp1_lo_q;
    logic [7:0] dp1_hi_q;
    logic sel_q;
    logic baud_q;
    logic uflag1_q;
    logic uflag0_q;
    logic [7:0] dirl_q;
    logic [7:0] dirh_q;
    cpp_pkg::cpp_mode_e mode_q;
    cpp_pkg::cpp_mode_e mode_d;
    logic [7:0] p0_out_q;
    logic [7:0] p0_oe_q;
    logic [7:0] rdata_q;
    logic [7:0] ext_rdata_q;
    logic [15:0] adp_q;
    logic [7:0] stack_addr_q;
    logic freeze_q;
    logic halt_q;
    logic ref_q;
    logic baud_out_q;

    cpp_stk_if stk();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = sfr_wr && (a == b);
    endfunction

    // Writes are ignored while frozen; only the bank itself decides that
    wire active_w = (mode_q == cpp_pkg::CPP_RUN);
    wire wr_ok = active_w;
    wire w_p0 = wr_ok && hit(sfr_addr, cpp_pkg::ADDR_PORT0);
    wire w_dp0_lo = wr_ok && hit(sfr_addr, cpp_pkg::ADDR_DP0_LOW);
    wire w_dp0_hi = wr_ok && hit(sfr_addr, cpp_pkg::ADDR_DP0_HIGH);
    wire w_dp1_lo = wr_ok && hit(sfr_addr, cpp_pkg::ADDR_DP1_LOW);
    wire w_dp1_hi = wr_ok && hit(sfr_addr, cpp_pkg::ADDR_DP1_HIGH);
    wire w_sel = wr_ok && hit(sfr_addr, cpp_pkg::ADDR_PTR_SEL);
    wire w_power = wr_ok && hit(sfr_addr, cpp_pkg::ADDR_POWER);
    wire w_dirl = wr_ok && hit(sfr_addr, cpp_pkg::ADDR_DIR_LOW);
    wire w_dirh = wr_ok && hit(sfr_addr, cpp_pkg::ADDR_DIR_HIGH);
    wire w_sp = wr_ok && hit(sfr_addr, cpp_pkg::ADDR_SP);

    assign stk.push = stack_push && active_w;
    assign stk.pop = stack_pop && active_w;
    assign stk.wr_en = w_sp;
    assign stk.wr_data = sfr_wdata;

    cpp_stack u_stack
    (
        .clk(clk),
        .reset(reset),
        .stk(stk)
    );

    wire [15:0] dp0_w = {dp0_hi_q, dp0_lo_q};
    wire [15:0] dp1_w = {dp1_hi_q, dp1_lo_q};
    wire [15:0] adp_w = sel_q ? dp1_w : dp0_w;

    // Stop and idle request bits read as zero; fixed bits read constant
    wire [7:0] power_rd = cpp_pkg::POWER_FIXED
        | ({7'h00, baud_q} << cpp_pkg::PC_BAUD)
        | ({7'h00, uflag1_q} << cpp_pkg::PC_FLAG1)
        | ({7'h00, uflag0_q} << cpp_pkg::PC_FLAG0);
    wire [7:0] sel_rd = {7'h00, sel_q};

    wire [7:0] rd_mux =
        (sfr_addr == cpp_pkg::ADDR_PORT0) ? port0_q :
        (sfr_addr == cpp_pkg::ADDR_SP) ? stk.sp :
        (sfr_addr == cpp_pkg::ADDR_DP0_LOW) ? dp0_lo_q :
        (sfr_addr == cpp_pkg::ADDR_DP0_HIGH) ? dp0_hi_q :
        (sfr_addr == cpp_pkg::ADDR_DP1_LOW) ? dp1_lo_q :
        (sfr_addr == cpp_pkg::ADDR_DP1_HIGH) ? dp1_hi_q :
        (sfr_addr == cpp_pkg::ADDR_PTR_SEL) ? sel_rd :
        (sfr_addr == cpp_pkg::ADDR_POWER) ? power_rd :
        (sfr_addr == cpp_pkg::ADDR_DIR_LOW) ? dirl_q :
        (sfr_addr == cpp_pkg::ADDR_DIR_HIGH) ? dirh_q : 8'h00;

    // Bus mode: address while strobe high, data while low
    wire bus_w = hw_config_bus_mode && ext_cycle;
    wire [7:0] bus_out_w = ext_ale ? ext_addr_low : ext_wdata;
    wire [7:0] bus_oe_w = (ext_ale || ext_write) ? 8'hFF : 8'h00;
    // GPIO: high direction bit set gives push-pull, low bit alone gives open-drain low, neither drives
    wire [7:0] gpio_oe_w = dirh_q | (dirl_q & ~port0_q);
    wire [7:0] p0_out_d = bus_w ? bus_out_w : port0_q;
    wire [7:0] p0_oe_d = bus_w ? bus_oe_w : gpio_oe_w;

    wire wake_w = aux_irq_wake || wake_up_irq;
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            cpp_pkg::CPP_RUN:
            begin
                if (w_power && sfr_wdata[cpp_pkg::PC_STOP])
                    mode_d = cpp_pkg::CPP_STOP;
                else if (w_power && sfr_wdata[cpp_pkg::PC_IDLE])
                    mode_d = cpp_pkg::CPP_IDLE;
            end
            cpp_pkg::CPP_IDLE:
            begin
                if (wake_w)
                    mode_d = cpp_pkg::CPP_RUN;
            end
            cpp_pkg::CPP_STOP:
                mode_d = cpp_pkg::CPP_STOP;
            default:
                mode_d = cpp_pkg::CPP_RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            mode_q <= cpp_pkg::CPP_RUN;
        else
            mode_q <= mode_d;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            port0_q <= cpp_pkg::RST_PORT0;
            dp0_lo_q <= cpp_pkg::RST_BYTE;
            dp0_hi_q <= cpp_pkg::RST_BYTE;
            dp1_lo_q <= cpp_pkg::RST_BYTE;
            dp1_hi_q <= cpp_pkg::RST_BYTE;
            dirl_q <= cpp_pkg::RST_BYTE;
            dirh_q <= cpp_pkg::RST_BYTE;
        end
        else
        begin
            if (w_p0)
                port0_q <= sfr_wdata;
            if (w_dp0_lo)
                dp0_lo_q <= sfr_wdata;
            if (w_dp0_hi)
                dp0_hi_q <= sfr_wdata;
            if (w_dp1_lo)
                dp1_lo_q <= sfr_wdata;
            if (w_dp1_hi)
                dp1_hi_q <= sfr_wdata;
            if (w_dirl)
                dirl_q <= sfr_wdata;
            if (w_dirh)
                dirh_q <= sfr_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sel_q <= 1'b0;
            baud_q <= 1'b0;
            uflag1_q <= 1'b0;
            uflag0_q <= 1'b0;
        end
        else
        begin
            if (w_sel)
                sel_q <= sfr_wdata[cpp_pkg::PTR_SEL_BIT];
            if (w_power)
            begin
                baud_q <= sfr_wdata[cpp_pkg::PC_BAUD];
                uflag1_q <= sfr_wdata[cpp_pkg::PC_FLAG1];
                uflag0_q <= sfr_wdata[cpp_pkg::PC_FLAG0];
            end
        end
    end

    // Pins hold their last values in stop and idle
    wire hold_w = (mode_q != cpp_pkg::CPP_RUN);
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            p0_out_q <= cpp_pkg::RST_PORT0;
            p0_oe_q <= cpp_pkg::RST_BYTE;
            rdata_q <= cpp_pkg::RST_BYTE;
            ext_rdata_q <= cpp_pkg::RST_BYTE;
            adp_q <= 16'h0000;
            stack_addr_q <= cpp_pkg::RST_SP;
            freeze_q <= 1'b0;
            halt_q <= 1'b0;
            ref_q <= 1'b0;
            baud_out_q <= 1'b0;
        end
        else
        begin
            if (!hold_w)
            begin
                p0_out_q <= p0_out_d;
                p0_oe_q <= p0_oe_d;
            end
            if (sfr_rd)
                rdata_q <= rd_mux;
            if (bus_w && !ext_ale && !ext_write)
                ext_rdata_q <= port_zero_in;
            adp_q <= adp_w;
            stack_addr_q <= stk.addr;
            freeze_q <= (mode_d != cpp_pkg::CPP_RUN);
            halt_q <= (mode_d == cpp_pkg::CPP_STOP);
            ref_q <= (mode_d == cpp_pkg::CPP_STOP);
            baud_out_q <= baud_q;
        end
    end

    assign sfr_rdata = rdata_q;
    assign port_zero_out = p0_out_q;
    assign port_zero_oe = p0_oe_q;
    assign port_zero_dir_low = dirl_q;
    assign port_zero_dir_high = dirh_q;
    assign ext_rdata = ext_rdata_q;
    assign active_data_pointer = adp_q;
    assign stack_addr = stack_addr_q;
    assign uart0_baud_doubler = baud_out_q;
    assign core_freeze = freeze_q;
    assign osc_halt = halt_q;
    assign ref_shutdown = ref_q;

    property p_stop_sticky;
        @(posedge clk) disable iff (reset)
        osc_halt |=> osc_halt && core_freeze;
    endproperty
    a_stop_sticky: assert property (p_stop_sticky)
        else $error("stop mode left without reset");

    property p_stop_enter;
        @(posedge clk) disable iff (reset)
        (active_w && w_power && sfr_wdata[cpp_pkg::PC_STOP])
            |=> osc_halt && ref_shutdown;
    endproperty
    a_stop_enter: assert property (p_stop_enter)
        else $error("stop request did not halt clock");

    property p_idle_enter;
        @(posedge clk) disable iff (reset)
        (w_power && sfr_wdata[cpp_pkg::PC_IDLE]
            && !sfr_wdata[cpp_pkg::PC_STOP])
            |=> core_freeze && !osc_halt;
    endproperty
    a_idle_enter: assert property (p_idle_enter)
        else $error("idle request did not freeze core");

    property p_idle_wake;
        @(posedge clk) disable iff (reset)
        (mode_q == cpp_pkg::CPP_IDLE && wake_w) |=> !core_freeze;
    endproperty
    a_idle_wake: assert property (p_idle_wake)
        else $error("enabled interrupt did not end idle");

    property p_power_control_read;
        @(posedge clk) disable iff (reset)
        (sfr_rd && sfr_addr == cpp_pkg::ADDR_POWER) |=> sfr_rdata[1:0] == 2'b00
            && sfr_rdata[6:4] == 3'b011;
    endproperty
    a_power_control_read: assert property (p_power_control_read)
        else $error("power control constant bits read wrong");

    property p_dps_read;
        @(posedge clk) disable iff (reset)
        (sfr_rd && sfr_addr == cpp_pkg::ADDR_PTR_SEL)
            |=> sfr_rdata[7:1] == 7'h00;
    endproperty
    a_dps_read: assert property (p_dps_read)
        else $error("pointer select upper bits not zero");

    property p_active_data_pointer_sel;
        @(posedge clk) disable iff (reset)
        1'b1 |=> active_data_pointer ==
            ($past(sel_q) ? {$past(dp1_hi_q), $past(dp1_lo_q)}
                          : {$past(dp0_hi_q), $past(dp0_lo_q)});
    endproperty
    a_active_data_pointer_sel: assert property (p_active_data_pointer_sel)
        else $error("active data pointer wrong");

    property p_bus_addr;
        @(posedge clk) disable iff (reset)
        (active_w && bus_w && ext_ale) |=> port_zero_out == $past(ext_addr_low)
            && port_zero_oe == 8'hFF;
    endproperty
    a_bus_addr: assert property (p_bus_addr)
        else $error("port zero did not carry address");

    property p_gpio_oe;
        @(posedge clk) disable iff (reset)
        (active_w && !hw_config_bus_mode) |=> port_zero_oe ==
            ($past(dirh_q) | ($past(dirl_q) & ~$past(port0_q)));
    endproperty
    a_gpio_oe: assert property (p_gpio_oe)
        else $error("port zero drive wrong in gpio");

    property p_flags;
        @(posedge clk) disable iff (reset)
        w_power |=> (uflag1_q == $past(sfr_wdata[cpp_pkg::PC_FLAG1]))
            && (uflag0_q == $past(sfr_wdata[cpp_pkg::PC_FLAG0]));
    endproperty
    a_flags: assert property (p_flags)
        else $error("user flag not stored");
endmodule

/* File: pkg/cpp_pkg.sv */
// Behaviour
// - Port zero: address while strobe high, data low
// - Config bit picks port I/O or bus
// - GPIO drive type follows two direction registers
// - Stack pointer resets to 07h
// - Push or call: increment, then write
// - Pop or return: read, then decrement
// - Two 16-bit pointers from low and high
// - Select bit picks pointer zero or one
// - Baud doubler bit doubles serial port rate
// - Two free user flags, no hardware effect
// - Stop request halts clock to logic
// - Stop request bit reads zero
// - Stop holds pins, reference off, reset exits
// - Idle freezes core, timers, serial ports
// - Idle request bit reads zero
// - Enabled aux or wake interrupt ends idle
package cpp_pkg;
    localparam logic [7:0] ADDR_PORT0 = 8'h80;
    localparam logic [7:0] ADDR_SP = 8'h81;
    localparam logic [7:0] ADDR_DP0_LOW = 8'h82;
    localparam logic [7:0] ADDR_DP0_HIGH = 8'h83;
    localparam logic [7:0] ADDR_DP1_LOW = 8'h84;
    localparam logic [7:0] ADDR_DP1_HIGH = 8'h85;
    localparam logic [7:0] ADDR_PTR_SEL = 8'h86;
    localparam logic [7:0] ADDR_POWER = 8'h87;
    localparam logic [7:0] ADDR_DIR_LOW = 8'hAC;
    localparam logic [7:0] ADDR_DIR_HIGH = 8'hAD;
    localparam logic [7:0] RST_PORT0 = 8'hFF;
    localparam logic [7:0] RST_SP = 8'h07;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_POWER = 8'h30;
    localparam logic [7:0] POWER_FIXED = 8'h30;
    localparam int PC_BAUD = 7;
    localparam int PC_FLAG1 = 3;
    localparam int PC_FLAG0 = 2;
    localparam int PC_STOP = 1;
    localparam int PC_IDLE = 0;
    localparam int PTR_SEL_BIT = 0;
    localparam logic [7:0] ONE = 8'h01;
    typedef enum logic [1:0]
    {
        CPP_RUN = 2'b00,
        CPP_IDLE = 2'b01,
        CPP_STOP = 2'b10
    } cpp_mode_e;
endpackage

/* File: pkg/cpp_stk_if.sv */
`timescale 1ns/1ps
interface cpp_stk_if;
    logic push;
    logic pop;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] sp;
    logic [7:0] addr;
    modport owner
    (
        input push,
        input pop,
        input wr_en,
        input wr_data,
        output sp,
        output addr
    );
    modport user
    (
        output push,
        output pop,
        output wr_en,
        output wr_data,
        input sp,
        input addr
    );
endinterface

/* File: core/cpp_stack.sv */
`timescale 1ns/1ps
module cpp_stack
(
    input wire logic clk,
    input wire logic reset,
    cpp_stk_if.owner stk
);
    logic [7:0] sp_q;
    logic [7:0] sp_d;
    logic [7:0] inc_w;
    logic [7:0] dec_w;

    assign inc_w = sp_q + cpp_pkg::ONE;
    assign dec_w = sp_q - cpp_pkg::ONE;
    // Push addresses the incremented slot; pop reads current slot
    assign stk.addr = stk.push ? inc_w : sp_q;
    assign sp_d = stk.push ? inc_w : (stk.pop ? dec_w :
        (stk.wr_en ? stk.wr_data : sp_q));
    assign stk.sp = sp_q;

    always_ff @(posedge clk)
    begin
        if (reset)
            sp_q <= cpp_pkg::RST_SP;
        else
            sp_q <= sp_d;
    end

    property p_push_inc;
        @(posedge clk) disable iff (reset)
        stk.push |=> sp_q == $past(sp_q) + 8'h01;
    endproperty
    a_push_inc: assert property (p_push_inc)
        else $error("push did not increment stack pointer");

    property p_pop_dec;
        @(posedge clk) disable iff (reset)
        (stk.pop && !stk.push) |-> stk.addr == sp_q ##1
            sp_q == $past(sp_q) - 8'h01;
    endproperty
    a_pop_dec: assert property (p_pop_dec)
        else $error("pop did not read then decrement");

    property p_sp_reset;
        @(posedge clk) reset |=> sp_q == 8'h07;
    endproperty
    a_sp_reset: assert property (p_sp_reset)
        else $error("stack pointer reset value wrong");
endmodule

/* File: test/cpp_ext_mem.sv */
`timescale 1ns/1ps
module cpp_ext_mem
(
    input wire logic clk,
    input wire logic ext_ale,
    input wire logic ext_read,
    input wire logic [7:0] port_zero_out,
    input wire logic [7:0] port_zero_oe,
    output logic [7:0] port_zero_in
);
    logic [7:0] addr_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic [7:0] far_d;
    // Memory data is a fixed function of the address latched on the strobe
    always @(posedge clk)
    begin
        if (ext_ale)
            addr_q <= port_zero_out;
        last_q <= port_zero_in;
    end
    // Undriven lines flip every cycle outside a read so a stale value never passes
    always_comb
    begin
        if (ext_read && !ext_ale)
            far_d = addr_q ^ 8'hA5;
        else
            far_d = ~last_q;
        port_zero_in = (port_zero_out & port_zero_oe) | (far_d & ~port_zero_oe);
    end
endmodule

/* File: test/cpp_sfr_bank_tb.sv */
`timescale 1ns/1ps
module cpp_sfr_bank_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic push = 1'b0;
    logic pop = 1'b0;
    logic bus_mode = 1'b0;
    logic ext_cycle = 1'b0;
    logic ale = 1'b0;
    logic [7:0] ext_addr = 8'h00;
    logic [7:0] ext_wdata = 8'h00;
    logic ext_write = 1'b0;
    logic aux_wake = 1'b0;
    logic wake_irq = 1'b0;
    logic [7:0] sfr_rdata, stack_addr, p0_in, p0_out, p0_oe, dir_lo, ext_rdata;
    logic [7:0] dir_hi;
    logic [15:0] adp;
    logic baud, freeze, halt, ref_off;
    logic [7:0] rst_tab [8] = '{8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h30};
    int checked = 0;
    int n_mismatch = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    cpp_sfr_bank uut
    (
        .clk(clk), .reset(reset), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .stack_push(push), .stack_pop(pop), .stack_addr(stack_addr),
        .active_data_pointer(adp), .hw_config_bus_mode(bus_mode),
        .ext_cycle(ext_cycle), .ext_ale(ale), .ext_addr_low(ext_addr),
        .ext_wdata(ext_wdata), .ext_write(ext_write),
        .port_zero_in(p0_in), .port_zero_out(p0_out), .port_zero_oe(p0_oe),
        .port_zero_dir_low(dir_lo), .port_zero_dir_high(dir_hi),
        .ext_rdata(ext_rdata), .uart0_baud_doubler(baud),
        .aux_irq_wake(aux_wake), .wake_up_irq(wake_irq),
        .core_freeze(freeze), .osc_halt(halt), .ref_shutdown(ref_off)
    );
    cpp_ext_mem far
    (
        .clk(clk), .ext_ale(ale), .ext_read(ext_cycle & ~ext_write),
        .port_zero_out(p0_out), .port_zero_oe(p0_oe), .port_zero_in(p0_in)
    );
    task automatic results;
        begin
            $display("checked %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        begin
            checked++;
            if (got !== exp)
            begin
                n_mismatch++;
                $display("wrong value at %0t: got %h expected %h", $time,
                    got, exp);
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge clk);
            sfr_wr <= 1'b1;
            sfr_addr <= a;
            sfr_wdata <= d;
            @(posedge clk);
            sfr_wr <= 1'b0;
            #1;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        begin
            @(posedge clk);
            sfr_rd <= 1'b1;
            sfr_addr <= a;
            @(posedge clk);
            sfr_rd <= 1'b0;
            #1;
            chk(sfr_rdata, exp);
        end
    endtask
    // Pulses push (w 0) or pop (w 1), or a wake line when w is 2 or 3
    task automatic pulse(input int w);
        begin
            @(posedge clk);
            push <= (w == 0);
            pop <= (w == 1);
            aux_wake <= (w == 2);
            wake_irq <= (w == 3);
            @(posedge clk);
            {push, pop, aux_wake, wake_irq} <= 4'h0;
            #1;
        end
    endtask
    task automatic wait_n(input int n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            results();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(8'(8'h80 + i), rst_tab[i]);
        rd(8'h90, 8'h00);
        $display("test reset values done");
        wr(8'h82, 8'h34);
        wr(8'h83, 8'h12);
        wr(8'h84, 8'h78);
        wr(8'h85, 8'h56);
        wait_n(1);
        chk(adp, 16'h1234);
        wr(8'h86, 8'hFF);
        rd(8'h86, 8'h01);
        chk(adp, 16'h5678);
        wr(8'h86, 8'h00);
        $display("test data pointers done");
        wr(8'h81, 8'h20);
        pulse(0);
        chk(stack_addr, 8'h21);
        pulse(0);
        chk(stack_addr, 8'h22);
        pulse(1);
        chk(stack_addr, 8'h22);
        pulse(1);
        rd(8'h81, 8'h20);
        $display("test stack done");
        wr(8'h80, 8'h5A);
        wr(8'hAC, 8'hF0);
        wr(8'hAD, 8'h0F);
        wait_n(1);
        chk(p0_out, 8'h5A);
        chk(p0_oe, 8'hAF);
        chk(dir_lo, 8'hF0);
        chk(dir_hi, 8'h0F);
        @(posedge clk);
        {bus_mode, ext_cycle, ale} <= 3'h7;
        ext_addr <= 8'h3C;
        wait_n(2);
        chk(p0_out, 8'h3C);
        chk(p0_oe, 8'hFF);
        @(posedge clk);
        ale <= 1'b0;
        ext_write <= 1'b1;
        ext_wdata <= 8'hC3;
        wait_n(2);
        chk(p0_out, 8'hC3);
        @(posedge clk);
        ext_write <= 1'b0;
        wait_n(3);
        chk(ext_rdata, 8'h99);
        @(posedge clk);
        {bus_mode, ext_cycle} <= 2'h0;
        wait_n(2);
        chk(p0_out, 8'h5A);
        $display("test port zero done");
        wr(8'h87, 8'hFC);
        rd(8'h87, 8'hBC);
        chk(baud, 1'b1);
        for (int k = 2; k < 4; k++)
        begin
            wr(8'h87, 8'h01);
            chk(freeze, 1'b1);
            wr(8'h81, 8'h55);
            chk(baud, 1'b0);
            rd(8'h81, 8'h20);
            rd(8'h87, 8'h30);
            pulse(k);
            chk(freeze, 1'b0);
        end
        $display("test idle done");
        wr(8'h87, 8'h02);
        chk({freeze, halt, ref_off}, 3'h7);
        rd(8'h87, 8'h30);
        wr(8'h80, 8'h00);
        pulse(2);
        chk(freeze, 1'b1);
        chk(p0_out, 8'h5A);
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk({freeze, halt, ref_off}, 3'h0);
        rd(8'h80, 8'hFF);
        rd(8'h81, 8'h07);
        $display("test stop done");
        results();
    end
endmodule
